// *** common/pacc_pkg.sv ***
// Constants for the pulse accumulator flag and interrupt block
package pacc_pkg;
  localparam int          COUNT_W      = 8;
  localparam logic [7:0]  COUNT_MAX    = 8'hFF;
  localparam logic [7:0]  COUNT_ZERO   = 8'h00;
  localparam int          FLAG_OVF_BIT = 5;
  localparam int          FLAG_EDG_BIT = 4;
  localparam logic        FLAG_RESET   = 1'h0;
  localparam logic        EDGE_FALLING = 1'h0;
  localparam logic        EDGE_RISING  = 1'h1;
  localparam logic        MODE_EVENT   = 1'h0;
  localparam logic        MODE_GATED   = 1'h1;
endpackage

// *** hw/pacc_edge.sv ***
// Edge detector for the accumulator input pin
`timescale 1ns/1ns
module pacc_edge (
  input  wire logic CLK_SYS_IN,
  input  wire logic RESETN_IN,
  input  wire logic pin_in,
  output logic      rise_out,
  output logic      fall_out
);
  logic prev_ff;
  logic nxt_prev;
  logic vld_ff;
  logic nxt_vld;

  always_comb begin
    nxt_prev = pin_in;
    nxt_vld  = 1'h1;
  end

  always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      prev_ff <= 1'h0;
      vld_ff  <= 1'h0;
    end else begin
      prev_ff <= nxt_prev;
      vld_ff  <= nxt_vld;
    end
  end

  // History counts only after one sampled cycle, so a pin held high through reset is no edge
  assign rise_out = vld_ff & pin_in & ~prev_ff;
  assign fall_out = vld_ff & ~pin_in & prev_ff;
endmodule

// *** hw/pacc_flags.sv ***
// Pulse accumulator counter, status flags and interrupt requests
// Function
// - Set overflow flag on count wrap FF to 00
// - Writing one at flag bit 5 clears overflow
// - Overflow enable gates interrupt only, not flag
// - Overflow enable low: no overflow request
// - Overflow enable high: request when flag set
// - Set edge flag on each selected input edge while system enabled
// - Writing one at flag bit 4 clears edge
// - Edge enable never affects edge flag
// - Edge enable low: no edge request
// - Edge enable high: request when flag set
// - Edge select picks edge, or inhibit level
// - Accumulator runs only when system enabled
// - Count survives reset, software read/write anytime
`timescale 1ns/1ns
module pacc_flags #(
  parameter int COUNT_W = pacc_pkg::COUNT_W
) (
  input  wire logic               CLK_SYS_IN,
  input  wire logic               RESETN_IN,
  input  wire logic               ACCUM_INPUT_PIN_IN,
  input  wire logic               ACCUM_SYSTEM_ENABLE_IN,
  input  wire logic               ACCUM_MODE_SELECT_IN,
  input  wire logic               EDGE_SELECT_IN,
  input  wire logic               OVF_IRQ_ENABLE_IN,
  input  wire logic               EDGE_IRQ_ENABLE_IN,
  input  wire logic               FLAG_WR_IN,
  input  wire logic [7:0]         FLAG_WDATA_IN,
  input  wire logic               COUNT_WR_IN,
  input  wire logic [COUNT_W-1:0] COUNT_WDATA_IN,
  output logic [COUNT_W-1:0]      ACCUM_COUNT_OUT,
  output logic                    OVF_FLAG_OUT,
  output logic                    EDGE_FLAG_OUT,
  output logic                    OVF_IRQ_OUT,
  output logic                    EDGE_IRQ_OUT
);
  logic [COUNT_W-1:0] count_ff;
  logic [COUNT_W-1:0] nxt_count;
  logic               ovf_flag_ff;
  logic               nxt_ovf_flag;
  logic               edge_flag_ff;
  logic               nxt_edge_flag;
  logic               rise;
  logic               fall;
  logic               sel_edge;
  logic               count_step;
  logic               wrap;

  pacc_edge pacc_edge_i (
    .CLK_SYS_IN (CLK_SYS_IN),
    .RESETN_IN  (RESETN_IN),
    .pin_in     (ACCUM_INPUT_PIN_IN),
    .rise_out   (rise),
    .fall_out   (fall)
  );

  always_comb begin
    sel_edge = (EDGE_SELECT_IN == pacc_pkg::EDGE_RISING) ? rise : fall;
    count_step = 1'h0;
    if (ACCUM_SYSTEM_ENABLE_IN) begin
      if (ACCUM_MODE_SELECT_IN == pacc_pkg::MODE_EVENT) begin
        count_step = sel_edge;
      end else begin
        count_step = (ACCUM_INPUT_PIN_IN != EDGE_SELECT_IN);
      end
    end
    wrap = count_step && (count_ff == {COUNT_W{1'b1}});
    if (COUNT_WR_IN) begin
      nxt_count = COUNT_WDATA_IN;
      wrap = 1'h0;
    end else if (count_step) begin
      nxt_count = count_ff + {{(COUNT_W-1){1'b0}}, 1'b1};
    end else begin
      nxt_count = count_ff;
    end
  end

  // Count has no reset so it keeps its value across chip reset
  always_ff @(posedge CLK_SYS_IN) begin
    count_ff <= nxt_count;
  end

  always_comb begin
    nxt_ovf_flag = ovf_flag_ff;
    nxt_edge_flag = edge_flag_ff;
    if (FLAG_WR_IN && FLAG_WDATA_IN[pacc_pkg::FLAG_OVF_BIT]) begin
      nxt_ovf_flag = 1'h0;
    end
    if (FLAG_WR_IN && FLAG_WDATA_IN[pacc_pkg::FLAG_EDG_BIT]) begin
      nxt_edge_flag = 1'h0;
    end
    // Set wins over a simultaneous clear
    if (wrap) begin
      nxt_ovf_flag = 1'h1;
    end
    if (ACCUM_SYSTEM_ENABLE_IN && sel_edge) begin
      nxt_edge_flag = 1'h1;
    end
  end

  always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      ovf_flag_ff  <= pacc_pkg::FLAG_RESET;
      edge_flag_ff <= pacc_pkg::FLAG_RESET;
    end else begin
      ovf_flag_ff  <= nxt_ovf_flag;
      edge_flag_ff <= nxt_edge_flag;
    end
  end

  assign ACCUM_COUNT_OUT = count_ff;
  assign OVF_FLAG_OUT    = ovf_flag_ff;
  assign EDGE_FLAG_OUT   = edge_flag_ff;
  assign OVF_IRQ_OUT     = ovf_flag_ff & OVF_IRQ_ENABLE_IN;
  assign EDGE_IRQ_OUT    = edge_flag_ff & EDGE_IRQ_ENABLE_IN;

  chk_ovf_sets: assert property (@(posedge CLK_SYS_IN) disable iff (!RESETN_IN)
    wrap |=> OVF_FLAG_OUT)
    else $error("overflow flag not set after wrap");
  chk_ovf_clear: assert property (@(posedge CLK_SYS_IN) disable iff (!RESETN_IN)
    (FLAG_WR_IN && FLAG_WDATA_IN[pacc_pkg::FLAG_OVF_BIT] && !wrap) |=> !OVF_FLAG_OUT)
    else $error("overflow flag not cleared by one-write");
  chk_ovf_indep: assert property (@(posedge CLK_SYS_IN) disable iff (!RESETN_IN)
    (!OVF_FLAG_OUT && !wrap) |=> !OVF_FLAG_OUT)
    else $error("overflow flag set without wrap");
  chk_ovf_irq_off: assert property (@(posedge CLK_SYS_IN) disable iff (!RESETN_IN)
    !OVF_IRQ_ENABLE_IN |-> !OVF_IRQ_OUT)
    else $error("overflow request while disabled");
  chk_ovf_irq_on: assert property (@(posedge CLK_SYS_IN) disable iff (!RESETN_IN)
    (wrap && OVF_IRQ_ENABLE_IN) ##1 OVF_IRQ_ENABLE_IN |-> OVF_IRQ_OUT)
    else $error("overflow request missing");
  chk_edge_sets: assert property (@(posedge CLK_SYS_IN) disable iff (!RESETN_IN)
    (ACCUM_SYSTEM_ENABLE_IN && sel_edge) |=> EDGE_FLAG_OUT)
    else $error("edge flag not set");
  chk_edge_clear: assert property (@(posedge CLK_SYS_IN) disable iff (!RESETN_IN)
    (FLAG_WR_IN && FLAG_WDATA_IN[pacc_pkg::FLAG_EDG_BIT] && !(ACCUM_SYSTEM_ENABLE_IN && sel_edge))
    |=> !EDGE_FLAG_OUT)
    else $error("edge flag not cleared by one-write");
  chk_flag_sticky: assert property (@(posedge CLK_SYS_IN) disable iff (!RESETN_IN)
    (EDGE_FLAG_OUT && !(FLAG_WR_IN && FLAG_WDATA_IN[pacc_pkg::FLAG_EDG_BIT])) |=> EDGE_FLAG_OUT)
    else $error("edge flag dropped without clear");
  chk_ovf_sticky: assert property (@(posedge CLK_SYS_IN) disable iff (!RESETN_IN)
    (OVF_FLAG_OUT && !(FLAG_WR_IN && FLAG_WDATA_IN[pacc_pkg::FLAG_OVF_BIT])) |=> OVF_FLAG_OUT)
    else $error("overflow flag dropped without clear");
  chk_ovf_irq_eq: assert property (@(posedge CLK_SYS_IN) disable iff (!RESETN_IN)
    OVF_IRQ_OUT == (OVF_FLAG_OUT && OVF_IRQ_ENABLE_IN))
    else $error("overflow request mismatch");
  chk_edge_irq_off: assert property (@(posedge CLK_SYS_IN) disable iff (!RESETN_IN)
    !EDGE_IRQ_ENABLE_IN |-> !EDGE_IRQ_OUT)
    else $error("edge request while disabled");
  chk_edge_irq_on: assert property (@(posedge CLK_SYS_IN) disable iff (!RESETN_IN)
    (ACCUM_SYSTEM_ENABLE_IN && sel_edge && EDGE_IRQ_ENABLE_IN) ##1 EDGE_IRQ_ENABLE_IN
    |-> EDGE_IRQ_OUT)
    else $error("edge request missing");
  chk_edge_quiet: assert property (@(posedge CLK_SYS_IN) disable iff (!RESETN_IN)
    (!EDGE_FLAG_OUT && !(ACCUM_SYSTEM_ENABLE_IN && sel_edge)) |=> !EDGE_FLAG_OUT)
    else $error("edge flag set without edge");
  chk_edge_off: assert property (@(posedge CLK_SYS_IN) disable iff (!RESETN_IN)
    (!ACCUM_SYSTEM_ENABLE_IN && !EDGE_FLAG_OUT) |=> !EDGE_FLAG_OUT)
    else $error("edge flag set while disabled");
  chk_cnt_step: assert property (@(posedge CLK_SYS_IN) disable iff (!RESETN_IN)
    (count_step && !COUNT_WR_IN)
    |=> ACCUM_COUNT_OUT == COUNT_W'($past(ACCUM_COUNT_OUT) + 1'b1))
    else $error("count did not step");
  chk_gate_hold: assert property (@(posedge CLK_SYS_IN) disable iff (!RESETN_IN)
    (ACCUM_MODE_SELECT_IN == pacc_pkg::MODE_GATED && ACCUM_INPUT_PIN_IN == EDGE_SELECT_IN
    && !COUNT_WR_IN) |=> $stable(ACCUM_COUNT_OUT))
    else $error("count moved while gated off");
  chk_event_hold: assert property (@(posedge CLK_SYS_IN) disable iff (!RESETN_IN)
    (ACCUM_MODE_SELECT_IN == pacc_pkg::MODE_EVENT && !sel_edge && !COUNT_WR_IN)
    |=> $stable(ACCUM_COUNT_OUT))
    else $error("count moved without selected edge");
  chk_wrap_zero: assert property (@(posedge CLK_SYS_IN) disable iff (!RESETN_IN)
    wrap |=> ACCUM_COUNT_OUT == '0)
    else $error("count not zero after wrap");
  chk_edge_irq: assert property (@(posedge CLK_SYS_IN) disable iff (!RESETN_IN)
    EDGE_IRQ_OUT == (EDGE_FLAG_OUT && EDGE_IRQ_ENABLE_IN))
    else $error("edge request mismatch");
  chk_disabled: assert property (@(posedge CLK_SYS_IN) disable iff (!RESETN_IN)
    (!ACCUM_SYSTEM_ENABLE_IN && !COUNT_WR_IN) |=> $stable(ACCUM_COUNT_OUT))
    else $error("count moved while disabled");
  chk_cnt_write: assert property (@(posedge CLK_SYS_IN) disable iff (!RESETN_IN)
    COUNT_WR_IN |=> ACCUM_COUNT_OUT == $past(COUNT_WDATA_IN))
    else $error("count write lost");

  cov_wrap: cover property (@(posedge CLK_SYS_IN) disable iff (!RESETN_IN) wrap);
  cov_ovf_irq: cover property (@(posedge CLK_SYS_IN) disable iff (!RESETN_IN) OVF_IRQ_OUT);
  cov_edge_irq: cover property (@(posedge CLK_SYS_IN) disable iff (!RESETN_IN) EDGE_IRQ_OUT);
  cov_gated: cover property (@(posedge CLK_SYS_IN) disable iff (!RESETN_IN)
    ACCUM_SYSTEM_ENABLE_IN && ACCUM_MODE_SELECT_IN && count_step);
endmodule

// *** verif/pacc_src.sv ***
// Pulse source model driving the accumulator input pin
`timescale 1ns/1ns
module pacc_src (
  input  wire logic clk_in,
  input  wire logic run_in,
  output logic      pin_out
);
  int hold = 0;
  initial pin_out = 1'h0;
  // Levels last one to six cycles, so fast and slow sources both occur
  always @(negedge clk_in) begin
    if (run_in && hold == 0) begin
      pin_out <= ~pin_out;
      hold <= $urandom % 6;
    end else if (hold > 0) begin
      hold <= hold - 1;
    end
  end
endmodule

// *** verif/test_pacc_flags.sv ***
// Self-checking bench for the pulse accumulator flag block
`timescale 1ns/1ns
module test_pacc_flags;
  logic CLK_SYS_IN = 1'h0, RESETN_IN = 1'h0, run = 1'h0, arm = 1'h0, pin;
  logic en = 1'h0, md = 1'h0, es = 1'h0, oie = 1'h0, eie = 1'h0, fwr = 1'h0, cwr = 1'h0;
  logic [7:0] fwd = 8'h00, cwd = 8'h00, cnt, m_cnt;
  logic ovf, edg, oirq, eirq, sel, stp, m_ovf = 1'h0, m_edg = 1'h0, m_prv = 1'h0, m_vld = 1'h0;
  logic [11:0] q[$];
  int n_fail = 0, check_count = 0;
  always #10 CLK_SYS_IN = ~CLK_SYS_IN;
  pacc_src pacc_src_i (.clk_in(CLK_SYS_IN), .run_in(run), .pin_out(pin));
  pacc_flags pacc_flags_i (.CLK_SYS_IN(CLK_SYS_IN), .RESETN_IN(RESETN_IN),
    .ACCUM_INPUT_PIN_IN(pin), .ACCUM_SYSTEM_ENABLE_IN(en), .ACCUM_MODE_SELECT_IN(md),
    .EDGE_SELECT_IN(es), .OVF_IRQ_ENABLE_IN(oie), .EDGE_IRQ_ENABLE_IN(eie),
    .FLAG_WR_IN(fwr), .FLAG_WDATA_IN(fwd), .COUNT_WR_IN(cwr), .COUNT_WDATA_IN(cwd),
    .ACCUM_COUNT_OUT(cnt), .OVF_FLAG_OUT(ovf), .EDGE_FLAG_OUT(edg), .OVF_IRQ_OUT(oirq),
    .EDGE_IRQ_OUT(eirq));
  task automatic check(input logic [11:0] got, input logic [11:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: outputs %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic test_done();
    if (n_fail == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Expected state noted at each edge from the sampled inputs
  always @(posedge CLK_SYS_IN) begin
    sel = m_vld & (es ? (pin & ~m_prv) : (~pin & m_prv));
    stp = en & ((md === pacc_pkg::MODE_EVENT) ? sel : (pin !== es));
    if (!RESETN_IN) begin
      m_ovf = 1'h0;
      m_edg = 1'h0;
      m_prv = 1'h0;
      m_vld = 1'h0;
    end else begin
      m_prv = pin;
      m_vld = 1'h1;
      m_ovf = (m_ovf & ~(fwr & fwd[5])) | (~cwr & stp & (m_cnt == 8'hFF));
      m_edg = (m_edg & ~(fwr & fwd[4])) | (en & sel);
    end
    m_cnt = cwr ? cwd : m_cnt + 8'(stp);
    if (arm) q.push_back({m_cnt, m_ovf, m_edg, m_ovf & oie, m_edg & eie});
  end
  always @(posedge CLK_SYS_IN) begin
    #5;
    while (q.size() > 0) check({cnt, ovf, edg, oirq, eirq}, q.pop_front());
  end
  task automatic cyc(input int n);
    for (int k = 0; k < n; k++) begin
      @(negedge CLK_SYS_IN);
      if (k % 32 == 0) {en, md, es, oie, eie} = 5'($urandom);
      fwr = ($urandom % 6) == 0;
      fwd = 8'($urandom);
      cwr = ($urandom % 90) == 0;
      cwd = 8'($urandom);
    end
  endtask
  initial begin
    void'($urandom(32'hFEDC));
    @(negedge CLK_SYS_IN);
    cwr = 1'h1;
    cwd = 8'hFE;
    repeat (3) @(negedge CLK_SYS_IN);
    cwr = 1'h0;
    RESETN_IN = 1'h1;
    arm = 1'h1;
    run = 1'h1;
    cyc(1500);
    @(negedge CLK_SYS_IN);
    RESETN_IN = 1'h0;
    {en, fwr, cwr} = 3'h0;
    repeat (2) @(negedge CLK_SYS_IN);
    RESETN_IN = 1'h1;
    cyc(1500);
    @(negedge CLK_SYS_IN);
    test_done();
  end
  initial begin
    #(3100 * 20 * 2);
    n_fail++;
    test_done();
  end
endmodule
